// ---- hw/cfr_chain.v ----
// Crest factor reduction chain: three pulse-cancellation engines and a hard clipper.
// Assumes one IQ sample per clock from upstream logic on the same clock.
//
// Summary of operation
// - Three engines in series, then hard clipper.
// - Detection threshold finds, correction threshold sets level.
// - Samples pass variable delay FIFO, corrected after.
// - Detector copy interpolated by one, two, four.
// - Detector reports peak position and excess.
// - Solver turns peaks into weights, lowers ratio.
// - Stored shaped pulse, time-shifted copies summed.
// - Pulse memory writable at startup and runtime.
// - Correction pulses are subtracted from samples.
// - Engine one feeds two, two feeds three.
// - Each engine output muxes corrected or bypassed.
// - Clipper limits samples above its threshold.
// - Each engine and clipper individually bypassable.
// - Coarse component test, then squared magnitude test.
// - Delay setting 129..511 gives setting plus one.
// - Clipper adds three cycles of latency.
// - Two stored pulses, selection picks active one.
`timescale 1ns/100ps
`include "cfr_chain_defines.vh"
module cfr_chain
(
    input  wire                   clk_sys_i,
    input  wire                   rst_i,
    input  wire signed [`DW-1:0]  in_i_i,
    input  wire signed [`DW-1:0]  in_q_i,
    input  wire [`DW-1:0]         peak_detect_level_i,
    input  wire [`DW-1:0]         correction_level_i,
    input  wire [`DW-1:0]         clip_level_i,
    input  wire [1:0]             interp_sel_i,
    input  wire [`DELAY_AW-1:0]   engine_delay_setting_i,
    input  wire [2:0]             engine_bypass_i,
    input  wire                   clip_bypass_i,
    input  wire                   pulse_sel_i,
    input  wire                   pulse_wr_i,
    input  wire                   pulse_wr_bank_i,
    input  wire [`PULSE_AW-1:0]   pulse_wr_addr_i,
    input  wire signed [`DW-1:0]  pulse_wr_i_i,
    input  wire signed [`DW-1:0]  pulse_wr_q_i,
    output reg  signed [`DW-1:0]  out_i_o,
    output reg  signed [`DW-1:0]  out_q_o,
    output reg                    clipped_o,
    output reg  [2:0]             peak_found_o
);
    function [15:0] sat20;
        input [19:0] v;
        begin
            if (v[19] && !(&v[18:15]))
                sat20 = 16'h8000;
            else if (!v[19] && (|v[18:15]))
                sat20 = 16'h7FFF;
            else
                sat20 = v[15:0];
        end
    endfunction
    function [16:0] absv;
        input [15:0] v;
        begin
            absv = v[15] ? (17'h00000 - {v[15], v}) : {1'b0, v};
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Shared settings and pulse memory
    ////////////////////////////////////////////////////////////////////////////
    reg  [2*`DW-1:0]      pulse_mem [0:2*`PULSE_LEN-1];
    wire [`DELAY_AW-1:0]  delay_eff = (engine_delay_setting_i < `DELAY_MIN) ?
                                      `DELAY_MIN : engine_delay_setting_i;
    wire [24:0]           thr_p  = {9'h000, peak_detect_level_i} * {16'h0000, `INV_SQRT2_Q8};
    wire [16:0]           thr_r2 = thr_p[24:8];
    wire [31:0]           thr_sq = peak_detect_level_i * peak_detect_level_i;
    reg  [15:0]           ts_q;

    // Either bank may be rewritten at any time, also while the chain runs
    always @(posedge clk_sys_i)
    begin
        if (pulse_wr_i)
            pulse_mem[{pulse_wr_bank_i, pulse_wr_addr_i}] <= {pulse_wr_i_i, pulse_wr_q_i};
    end
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
            ts_q <= 16'h0000;
        else
            ts_q <= ts_q + 16'h0001;
    end
    wire [`DW-1:0] st_i [0:`NUM_ENGINES];
    wire [`DW-1:0] st_q [0:`NUM_ENGINES];
    wire [2:0]     issue_w;
    assign st_i[0] = in_i_i;
    assign st_q[0] = in_q_i;

    ////////////////////////////////////////////////////////////////////////////
    // Pulse-cancellation engines
    ////////////////////////////////////////////////////////////////////////////
    genvar e, p, s;
    generate
        for (e = 0; e < `NUM_ENGINES; e = e + 1)
        begin : g_eng
            wire signed [15:0] x_i = st_i[e];
            wire signed [15:0] x_q = st_q[e];
            reg  signed [15:0] prv_i_q, prv_q_q;
            reg  signed [15:0] eo_i_q, eo_q_q;
            wire [31:0]        dl;
            wire [15:0]        ph_i [0:3];
            wire [15:0]        ph_q [0:3];
            wire [34:0]        m2 [0:3];
            wire [3:0]         hit;
            cfr_delay_line u_delay
            (
                .clk_sys_i (clk_sys_i),
                .rst_i     (rst_i),
                .delay_i   (delay_eff),
                .din_i     ({x_i, x_q}),
                .dout_o    (dl)
            );
            // Phase p sits (p+1)/4 of the way from the previous to the current sample
            for (p = 0; p < 4; p = p + 1)
            begin : g_ph
                wire signed [18:0] di = {{3{x_i[15]}}, x_i} - {{3{prv_i_q[15]}}, prv_i_q};
                wire signed [18:0] dq = {{3{x_q[15]}}, x_q} - {{3{prv_q_q[15]}}, prv_q_q};
                wire signed [18:0] kk = (p == 3) ? 19'sd4 : (p == 2) ? 19'sd3 :
                                        (p == 1) ? 19'sd2 : 19'sd1;
                wire signed [18:0] pi = {{3{prv_i_q[15]}}, prv_i_q} + ((di * kk) >>> 2);
                wire signed [18:0] pq = {{3{prv_q_q[15]}}, prv_q_q} + ((dq * kk) >>> 2);
                wire [16:0]        ai = absv(pi[15:0]);
                wire [16:0]        aq = absv(pq[15:0]);
                wire               en = (p == 3) || (interp_sel_i == `INTERP_X4) ||
                                        ((interp_sel_i == `INTERP_X2) && (p == 1));
                wire               coarse = (ai > thr_r2) || (aq > thr_r2);
                assign ph_i[p] = pi[15:0];
                assign ph_q[p] = pq[15:0];
                assign m2[p]   = coarse ? ({18'h00000, ai} * {18'h00000, ai} +
                                           {18'h00000, aq} * {18'h00000, aq}) : 35'h0;
                assign hit[p]  = en && coarse && (m2[p] > {3'h0, thr_sq});
            end
            // Largest hit of this cycle across the interpolated phases
            reg [34:0] bm;
            reg [15:0] bi, bq;
            reg [1:0]  bp;
            integer    j;
            always @*
            begin
                bm = 35'h0;
                bi = 16'h0000;
                bq = 16'h0000;
                bp = 2'h0;
                for (j = 0; j < 4; j = j + 1)
                    if (hit[j] && m2[j] >= bm)
                    begin
                        bm = m2[j];
                        bi = ph_i[j];
                        bq = ph_q[j];
                        bp = j[1:0];
                    end
            end

            // Consecutive hits, up to 31 cycles, form one group cancelled at its largest sample
            reg         grp_q;
            reg  [34:0] gm_q;
            reg  [15:0] gi_q, gq_q, gts_q;
            reg  [5:0]  glen_q;
            wire        any_hit = |hit;
            wire        issue = grp_q && (!any_hit || glen_q == `GROUP_LAST);
            assign issue_w[e] = issue;
            always @(posedge clk_sys_i)
            begin
                if (rst_i || issue)
                begin
                    grp_q  <= 1'b0;
                    gm_q   <= 35'h0;
                    glen_q <= 6'h00;
                end
                else if (any_hit)
                begin
                    grp_q  <= 1'b1;
                    glen_q <= glen_q + 6'h01;
                    if (!grp_q || bm > gm_q)
                    begin
                        gm_q  <= bm;
                        gi_q  <= bi;
                        gq_q  <= bq;
                        gts_q <= (bp <= 2'h1) ? ts_q - 16'h0001 : ts_q;
                    end
                end
            end

            // Solver: weight = peak * (|peak| - level) / |peak|
            wire [16:0] agi = absv(gi_q);
            wire [16:0] agq = absv(gq_q);
            wire [16:0] amx = (agi > agq) ? agi : agq;
            wire [16:0] amn = (agi > agq) ? agq : agi;
            wire [17:0] am  = {1'b0, amx} + (({1'b0, amn} * 18'd3) >> 3);
            wire        over = am > {2'b00, correction_level_i};
            wire [32:0] rnum = {15'h0000, am - {2'b00, correction_level_i}} << 15;
            wire [32:0] rq   = over ? rnum / {15'h0000, am} : 33'h0;
            wire signed [33:0] wip = $signed(gi_q) * $signed({1'b0, rq[15:0]});
            wire signed [33:0] wqp = $signed(gq_q) * $signed({1'b0, rq[15:0]});
            wire [15:0] age  = ts_q - gts_q;
            wire [9:0]  wst  = {1'b0, delay_eff} - `PULSE_HALF - 10'd2 - age[9:0];
            // Two correction slots let two peaks be cancelled at once
            wire [1:0]  free;
            wire [18:0] cs [0:1];
            wire [18:0] cq [0:1];
            for (s = 0; s < 2; s = s + 1)
            begin : g_slot
                reg        pend_q, act_q;
                reg [9:0]  wait_q;
                reg [4:0]  k_q;
                reg signed [15:0] wi_q, wq_q;
                wire       grant = issue && over && free[s] && (s == 0 || !free[0]);
                wire [31:0] tap = act_q ? pulse_mem[{pulse_sel_i, k_q}] : 32'h0;
                wire signed [31:0] pa = wi_q * $signed(tap[31:16]);
                wire signed [31:0] pb = wq_q * $signed(tap[15:0]);
                wire signed [31:0] pc = wi_q * $signed(tap[15:0]);
                wire signed [31:0] pd = wq_q * $signed(tap[31:16]);
                wire signed [32:0] ri = {pa[31], pa} - {pb[31], pb};
                wire signed [32:0] rqq = {pc[31], pc} + {pd[31], pd};
                assign free[s] = !pend_q && !act_q;
                assign cs[s] = {ri[32], ri[32:15]};
                assign cq[s] = {rqq[32], rqq[32:15]};
                always @(posedge clk_sys_i)
                begin
                    if (rst_i)
                    begin
                        pend_q <= 1'b0;
                        act_q  <= 1'b0;
                        wait_q <= 10'h000;
                        k_q    <= 5'h00;
                        wi_q   <= 16'h0000;
                        wq_q   <= 16'h0000;
                    end
                    else if (grant)
                    begin
                        pend_q <= 1'b1;
                        wait_q <= wst;
                        wi_q   <= wip[30:15];
                        wq_q   <= wqp[30:15];
                    end
                    else if (pend_q)
                    begin
                        // Pulse centre lands on the peak sample at the FIFO output
                        wait_q <= wait_q - 10'h001;
                        if (wait_q == 10'h000)
                        begin
                            pend_q <= 1'b0;
                            act_q  <= 1'b1;
                            k_q    <= 5'h00;
                        end
                    end
                    else if (act_q)
                    begin
                        k_q <= k_q + 5'h01;
                        if (k_q == `PULSE_LEN - 1)
                            act_q <= 1'b0;
                    end
                end
            end

            wire [19:0] csum_i = {cs[0][18], cs[0]} + {cs[1][18], cs[1]};
            wire [19:0] csum_q = {cq[0][18], cq[0]} + {cq[1][18], cq[1]};
            always @(posedge clk_sys_i)
            begin
                if (rst_i)
                begin
                    prv_i_q <= 16'h0000;
                    prv_q_q <= 16'h0000;
                    eo_i_q  <= 16'h0000;
                    eo_q_q  <= 16'h0000;
                end
                else
                begin
                    prv_i_q <= x_i;
                    prv_q_q <= x_q;
                    eo_i_q  <= sat20({{4{dl[31]}}, dl[31:16]} - csum_i);
                    eo_q_q  <= sat20({{4{dl[15]}}, dl[15:0]} - csum_q);
                end
            end

            // Bypassed engines pass their input straight on
            assign st_i[e+1] = engine_bypass_i[e] ? x_i : eo_i_q;
            assign st_q[e+1] = engine_bypass_i[e] ? x_q : eo_q_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Hard clipper, three-stage pipeline
    ////////////////////////////////////////////////////////////////////////////
    reg  signed [15:0] c1_i_q, c1_q_q, c2_i_q, c2_q_q;
    reg  [17:0]        c1_m_q;
    reg                c1_o_q, c2_o_q;
    reg  [16:0]        c2_r_q;
    wire [16:0]        ci_a = absv(st_i[`NUM_ENGINES]);
    wire [16:0]        cq_a = absv(st_q[`NUM_ENGINES]);
    wire [16:0]        cmx  = (ci_a > cq_a) ? ci_a : cq_a;
    wire [16:0]        cmn  = (ci_a > cq_a) ? cq_a : ci_a;
    wire [17:0]        cm   = {1'b0, cmx} + (({1'b0, cmn} * 18'd3) >> 3);
    wire [32:0]        crat = ({17'h00000, clip_level_i} << 15) / {15'h0000, c1_m_q};
    wire signed [33:0] cpi  = c2_i_q * $signed({1'b0, c2_r_q});
    wire signed [33:0] cpq  = c2_q_q * $signed({1'b0, c2_r_q});

    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            c1_i_q       <= 16'h0000;
            c1_q_q       <= 16'h0000;
            c1_m_q       <= 18'h00000;
            c1_o_q       <= 1'b0;
            c2_i_q       <= 16'h0000;
            c2_q_q       <= 16'h0000;
            c2_r_q       <= `UNITY_Q15;
            c2_o_q       <= 1'b0;
            out_i_o      <= 16'h0000;
            out_q_o      <= 16'h0000;
            clipped_o    <= 1'b0;
            peak_found_o <= 3'h0;
        end
        else
        begin
            c1_i_q       <= st_i[`NUM_ENGINES];
            c1_q_q       <= st_q[`NUM_ENGINES];
            c1_m_q       <= cm;
            c1_o_q       <= !clip_bypass_i && (cm > {2'b00, clip_level_i});
            c2_i_q       <= c1_i_q;
            c2_q_q       <= c1_q_q;
            c2_r_q       <= c1_o_q ? crat[16:0] : `UNITY_Q15;
            c2_o_q       <= c1_o_q;
            out_i_o      <= cpi[30:15];
            out_q_o      <= cpq[30:15];
            clipped_o    <= c2_o_q;
            peak_found_o <= issue_w;
        end
    end
endmodule // cfr_chain

// ---- hw/cfr_chain_defines.vh ----
// Constants for the crest factor reduction chain.
// Assumes one sample per clock on the transmit sample-rate clock.
`ifndef CFR_CHAIN_DEFINES_VH
`define CFR_CHAIN_DEFINES_VH
`define DW            16
`define NUM_ENGINES   3
`define PULSE_LEN     32
`define PULSE_AW      5
`define PULSE_HALF    10'd16
`define DELAY_MIN     9'd129
`define DELAY_MAX     9'd511
`define DELAY_AW      9
`define CLIP_LAT      3
`define INV_SQRT2_Q8  9'd181
`define GROUP_LAST    6'd31
`define UNITY_Q15     17'h08000
`define INTERP_X1     2'h0
`define INTERP_X2     2'h1
`define INTERP_X4     2'h2
`endif

// ---- hw/cfr_delay_line.v ----
// Variable delay FIFO carrying packed IQ samples.
// Assumes the delay setting is already clamped to its legal range.
`timescale 1ns/100ps
`include "cfr_chain_defines.vh"
module cfr_delay_line
(
    input  wire                   clk_sys_i,
    input  wire                   rst_i,
    input  wire [`DELAY_AW-1:0]   delay_i,
    input  wire [2*`DW-1:0]       din_i,
    output reg  [2*`DW-1:0]       dout_o
);
    reg  [2*`DW-1:0]      mem [0:(1<<`DELAY_AW)-1];
    reg  [`DELAY_AW-1:0]  wp_q;
    reg  [`DELAY_AW-1:0]  fill_q;
    wire [`DELAY_AW-1:0]  rp = wp_q - delay_i + 9'h001;

    // Output of the registered read is the sample written delay_i cycles ago
    always @(posedge clk_sys_i)
    begin
        mem[wp_q] <= din_i;
        if (rst_i)
        begin
            wp_q   <= 9'h000;
            fill_q <= 9'h000;
            dout_o <= 32'h00000000;
        end
        else
        begin
            wp_q <= wp_q + 9'h001;
            if (fill_q != 9'h1FF)
                fill_q <= fill_q + 9'h001;
            // Stale words after reset read as zero until the line has filled
            dout_o <= (fill_q >= delay_i - 9'h001) ? mem[rp] : 32'h00000000;
        end
    end
endmodule // cfr_delay_line

// ---- verif/cfr_chain_sva.sv ----
// Checker for the crest factor reduction chain, watching its top-level ports.
// Assumes settings stay static from one reset to the next.
`timescale 1ns/100ps
`include "cfr_chain_defines.vh"
module cfr_chain_sva
(
    input wire                   clk_sys_i,
    input wire                   rst_i,
    input wire signed [`DW-1:0]  in_i_i,
    input wire signed [`DW-1:0]  in_q_i,
    input wire [`DW-1:0]         peak_detect_level_i,
    input wire [`DW-1:0]         clip_level_i,
    input wire [`DELAY_AW-1:0]   engine_delay_setting_i,
    input wire [2:0]             engine_bypass_i,
    input wire                   clip_bypass_i,
    input wire signed [`DW-1:0]  out_i_o,
    input wire signed [`DW-1:0]  out_q_o,
    input wire                   clipped_o,
    input wire [2:0]             peak_found_o
);
    reg  [7:0]  warm_q;
    reg  [7:0]  quiet_q;
    wire [24:0] coarse_w = peak_detect_level_i * `INV_SQRT2_Q8;
    wire        hit_w;

    function [16:0] mag(input [15:0] v);
        mag = v[15] ? (17'h00000 - {v[15], v}) : {1'b0, v};
    endfunction

    assign hit_w = (mag(in_i_i) > coarse_w[24:8]) || (mag(in_q_i) > coarse_w[24:8]);

    // Cycles since reset release, and since the last input near the threshold
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            warm_q <= 8'h00;
            quiet_q <= 8'h00;
        end
        else
        begin
            warm_q <= warm_q + {7'h00, warm_q != 8'hFF};
            quiet_q <= hit_w ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hFF};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking

    reset_quiet_a: assert property (rst_i |=> out_i_o == 0 && out_q_o == 0
        && !clipped_o && peak_found_o == 3'h0) else $error("outputs not cleared by reset");
    bypass_latency_a: assert property (disable iff (rst_i)
        engine_bypass_i == 3'h7 && clip_bypass_i && warm_q >= 8'h04
        |-> out_i_o == $past(in_i_i, 3) && out_q_o == $past(in_q_i, 3))
        else $error("bypassed chain latency wrong");
    delay_latency_a: assert property (disable iff (rst_i)
        engine_bypass_i == 3'h6 && clip_bypass_i && engine_delay_setting_i == 9'h081
        && warm_q >= 8'h86 && quiet_q >= 8'h86 |-> out_i_o == $past(in_i_i, 133)
        && out_q_o == $past(in_q_i, 133)) else $error("engine delay wrong");
    clip_cause_a: assert property (disable iff (rst_i)
        engine_bypass_i == 3'h7 && !clip_bypass_i && warm_q >= 8'h04
        && $past(mag(in_i_i), 3) > {1'b0, clip_level_i} |-> clipped_o)
        else $error("large sample not clipped");
    clip_limit_a: assert property (disable iff (rst_i) clipped_o |->
        mag(out_i_o) <= {1'b0, clip_level_i} && mag(out_q_o) <= {1'b0, clip_level_i})
        else $error("clipped sample above clip level");
    clip_off_a: assert property (disable iff (rst_i)
        clip_bypass_i && $past(clip_bypass_i) && $past(clip_bypass_i, 2) |-> !clipped_o)
        else $error("clip flagged while bypassed");
    peak_pulse_a: assert property (disable iff (rst_i) peak_found_o[0] |=> !peak_found_o[0])
        else $error("peak report longer than one cycle");
    peak_quiet_a: assert property (disable iff (rst_i) quiet_q >= 8'h20 |-> !peak_found_o[0])
        else $error("peak reported without input above threshold");

    cover property (clipped_o);
    cover property (peak_found_o[0]);
    cover property (peak_found_o[1]);
endmodule // cfr_chain_sva

bind cfr_chain cfr_chain_sva chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .in_i_i(in_i_i),
    .in_q_i(in_q_i), .peak_detect_level_i(peak_detect_level_i), .clip_level_i(clip_level_i),
    .engine_delay_setting_i(engine_delay_setting_i), .engine_bypass_i(engine_bypass_i),
    .clip_bypass_i(clip_bypass_i), .out_i_o(out_i_o), .out_q_o(out_q_o),
    .clipped_o(clipped_o), .peak_found_o(peak_found_o));

// ---- verif/cfr_chain_test.sv ----
// Self-checking bench for the crest factor reduction chain.
// Assumes the chain and its checker are compiled alongside.
`timescale 1ns/100ps
`include "cfr_chain_defines.vh"
`define CHECK(got, exp) \
    begin \
        samples_checked = samples_checked + 1; \
        if ((got) !== (exp)) \
        begin \
            err_total = err_total + 1; \
            $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module cfr_chain_test;
    reg                   clk_sys_i;
    reg                   rst_i;
    reg                   run_src;
    reg  [15:0]           pk_lvl;
    reg  [15:0]           corr_lvl;
    reg  [15:0]           clip_lvl;
    reg  [1:0]            interp;
    reg  [8:0]            delay;
    reg  [2:0]            bypass;
    reg                   clip_bypass;
    reg                   pulse_sel;
    reg                   pulse_wr;
    reg                   wr_bank;
    reg  [4:0]            wr_addr;
    reg  signed [15:0]    wr_i;
    reg  signed [15:0]    wr_q;
    wire signed [15:0]    in_i;
    wire signed [15:0]    in_q;
    wire signed [15:0]    out_i;
    wire signed [15:0]    out_q;
    wire                  clipped;
    wire [2:0]            peak_found;
    reg  [31:0]           hist [0:1023];
    int                   err_total;
    int                   samples_checked;

    tx_sample_source src (.clk_sys_i(clk_sys_i), .run_i(run_src), .smp_i_o(in_i),
        .smp_q_o(in_q));
    cfr_chain uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .in_i_i(in_i), .in_q_i(in_q),
        .peak_detect_level_i(pk_lvl), .correction_level_i(corr_lvl), .clip_level_i(clip_lvl),
        .interp_sel_i(interp), .engine_delay_setting_i(delay), .engine_bypass_i(bypass),
        .clip_bypass_i(clip_bypass), .pulse_sel_i(pulse_sel), .pulse_wr_i(pulse_wr),
        .pulse_wr_bank_i(wr_bank), .pulse_wr_addr_i(wr_addr), .pulse_wr_i_i(wr_i),
        .pulse_wr_q_i(wr_q), .out_i_o(out_i), .out_q_o(out_q), .clipped_o(clipped),
        .peak_found_o(peak_found));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("samples checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Single-tap pulse: only the centre tap is non-zero
    task load(input bank, input [15:0] centre);
        int t;
        for (t = 0; t < 32; t++)
        begin
            @(negedge clk_sys_i);
            pulse_wr <= 1'b1;
            wr_bank <= bank;
            wr_addr <= t[4:0];
            wr_i <= (t == 16) ? centre : 16'h0000;
            wr_q <= 16'h0000;
        end
        @(negedge clk_sys_i);
        pulse_wr <= 1'b0;
    endtask

    // Reset, stream, and compare each output but the spike in modes 1 and 2 with the input one latency earlier
    task run(input [2:0] byp, input clb, input [8:0] dly, input [1:0] itp, input sel,
             input int mode, input int pk);
        int k;
        int lat;
        integer peaks;
        reg [31:0] e;
        lat = (3 - $countones(byp)) * (dly + 1) + `CLIP_LAT;
        peaks = 0;
        @(negedge clk_sys_i);
        bypass <= byp;
        clip_bypass <= clb;
        delay <= dly;
        interp <= itp;
        pulse_sel <= sel;
        rst_i <= 1'b1;
        run_src <= 1'b0;
        repeat (2) @(negedge clk_sys_i);
        rst_i <= 1'b0;
        run_src <= 1'b1;
        for (k = 0; k < lat + 200; k++)
        begin
            @(posedge clk_sys_i);
            #1;
            hist[k] = {in_i, in_q};
            e = (k - lat + 1 >= 0) ? hist[k - lat + 1] : 32'h0000_0000;
            peaks = peaks + $countones(peak_found);
            if (mode == 0 || e != 32'h4E20_0000)
                `CHECK({out_i, out_q}, e)
            else if (mode == 1)
                `CHECK(out_i >= 16'sh2328 && out_i <= 16'sh2AF8, 1'b1)
            else
                `CHECK({out_i >= 16'sh2CEC && out_i <= 16'sh2EE0, clipped}, 2'h3)
        end
        if (pk >= 0)
            `CHECK(peaks, pk)
        $display("test done bypass=%h delay=%h interp=%h sel=%h", byp, dly, itp, sel);
    endtask

    initial
    begin
        int m;
        err_total = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        run_src = 1'b0;
        pk_lvl = 16'h1F40;
        corr_lvl = 16'h2710;
        clip_lvl = 16'h2EE0;
        interp = 2'h0;
        delay = 9'h081;
        bypass = 3'h7;
        clip_bypass = 1'b1;
        pulse_sel = 1'b0;
        pulse_wr = 1'b0;
        wr_bank = 1'b0;
        wr_addr = 5'h00;
        wr_i = 16'h0000;
        wr_q = 16'h0000;
        repeat (6) @(negedge clk_sys_i);
        rst_i <= 1'b0;
        load(1'b0, 16'h7FFF);
        fork
            run(3'h7, 1'b1, 9'h081, 2'h0, 1'b0, 0, 3);
            begin
                repeat (8) @(negedge clk_sys_i);
                load(1'b1, 16'h0000);
            end
        join
        run(3'h7, 1'b0, 9'h081, 2'h0, 1'b0, 2, 3);
        for (m = 0; m < 3; m++)
            run(3'h6, 1'b1, 9'h081, m[1:0], 1'b0, 1, 3);
        run(3'h6, 1'b1, 9'h1FF, 2'h2, 1'b0, 1, 3);
        run(3'h6, 1'b1, 9'h081, 2'h0, 1'b1, 0, 3);
        run(3'h0, 1'b0, 9'h081, 2'h1, 1'b0, 1, 3);
        run(3'h5, 1'b1, 9'h081, 2'h0, 1'b0, 1, 3);
        end_of_test;
    end
endmodule // cfr_chain_test

// ---- verif/tx_sample_source.sv ----
// Upstream transmit sample source: one small IQ sample per clock, one large peak.
// Assumes the bench raises run_i when the chain leaves reset.
`timescale 1ns/100ps
`include "cfr_chain_defines.vh"
module tx_sample_source
#(
    parameter SPIKE_IDX = 150
)
(
    input  wire                   clk_sys_i,
    input  wire                   run_i,
    output reg  signed [`DW-1:0]  smp_i_o,
    output reg  signed [`DW-1:0]  smp_q_o
);
    reg [9:0] idx_q;

    initial
    begin
        idx_q = 10'h000;
        smp_i_o = 16'h0000;
        smp_q_o = 16'h0000;
    end

    // Samples change on the falling edge, one per clock
    always @(negedge clk_sys_i)
    begin
        if (!run_i)
        begin
            idx_q <= 10'h000;
            smp_i_o <= 16'h0000;
            smp_q_o <= 16'h0000;
        end
        else
        begin
            idx_q <= idx_q + 10'h001;
            smp_i_o <= (idx_q == SPIKE_IDX) ? 16'h4E20 : {6'h00, idx_q[5:0], 4'h0} - 16'h01F4;
            smp_q_o <= (idx_q == SPIKE_IDX) ? 16'h0000 : 16'h012C - {8'h00, idx_q[4:0], 3'h0};
        end
    end
endmodule // tx_sample_source
